// ===== inc/clock_sync_pkg.sv
// Operation
// - First-loop sync bit rising holds every divider sourced from the first loop in reset.
// - First-loop sync bit falling releases those dividers together, coarse phase cleared.
// - Second-loop sync bit rising holds every divider sourced from the second loop in reset.
// - Second-loop sync bit falling releases those dividers together, coarse phase cleared.
// - A five-bit field gives the coarse delay count for output seven.
// - Setting the coarse trigger bit applies the programmed delay to output seven; the code drops the trigger while the sync bit of output seven's loop holds it.
// - Each coarse step on output seven is one VCO period, 250 ps at 4 GHz.
// - Outputs two and three use a fine step of 16 ps instead.
package clock_sync_pkg;

	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned NUM_OUTPUTS   = 8;
	localparam int unsigned COUNT_W       = 5;

	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_TRIGGER   = 10'h09d;
	localparam logic [9:0]  IDX_COUNT     = 10'h0a5;
	localparam logic [9:0]  IDX_STEP      = 10'h0a6;
	localparam logic [9:0]  IDX_SOURCE_LO = 10'h0a8;
	localparam logic [9:0]  IDX_SOURCE_HI = 10'h0a9;

	// Field positions of the source and sync register and of the trigger register
	localparam int unsigned SRC_LO_POS    = 0;
	localparam int unsigned SYNC0_POS     = 4;
	localparam int unsigned SYNC1_POS     = 5;
	localparam int unsigned TRIGGER_POS   = 0;

	// Reset values
	localparam logic        SYNC_RESET    = 1'b0;
	localparam logic [3:0]  SRC_RESET     = 4'h0;
	localparam logic [4:0]  COUNT_RESET   = 5'h00;

	// Step sizes in picoseconds
	localparam int unsigned VCO_FREQ_MHZ  = 4000;
	localparam int unsigned VCO_STEP_PS   = 1000000 / VCO_FREQ_MHZ;
	localparam int unsigned FINE_STEP_PS  = 16;
	localparam logic [31:0] STEP_WORD     = {16'h0000, 8'(FINE_STEP_PS), 8'(VCO_STEP_PS)};

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic [7:0] div_reset;
		logic [7:0] phase_clear;
		logic       output_seven_hold;
	} divider_ctrl_type;

endpackage

// ===== rtl/output_divider_sync.sv
`timescale 1ns/1ps
module output_divider_sync
(
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [clock_sync_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output      logic                              s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output      logic                              s_axi_wready,
	output      logic [1:0]                        s_axi_bresp,
	output      logic                              s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [clock_sync_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output      logic                              s_axi_arready,
	output      logic [31:0]                       s_axi_rdata,
	output      logic [1:0]                        s_axi_rresp,
	output      logic                              s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	output      clock_sync_pkg::divider_ctrl_type  divider_ctrl
);

	// ==========================================================
	// Bus write path
	logic       aw_got_ff;
	logic [9:0] aw_idx_ff;
	logic       w_got_ff;
	logic [7:0] wdata_ff;
	logic       wlane_ff;
	logic       bvalid_ff;
	logic [1:0] bresp_ff;

	wire aw_take  = s_axi_awvalid && s_axi_awready;
	wire w_take   = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;
	wire wr_en    = do_write && wlane_ff;

	wire hit_trig   = aw_idx_ff == clock_sync_pkg::IDX_TRIGGER;
	wire hit_count  = aw_idx_ff == clock_sync_pkg::IDX_COUNT;
	wire hit_step   = aw_idx_ff == clock_sync_pkg::IDX_STEP;
	wire hit_src_lo = aw_idx_ff == clock_sync_pkg::IDX_SOURCE_LO;
	wire hit_src_hi = aw_idx_ff == clock_sync_pkg::IDX_SOURCE_HI;
	wire wr_mapped  = hit_trig || hit_count || hit_step || hit_src_lo || hit_src_hi;

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			aw_idx_ff <= 10'h000;
			w_got_ff  <= 1'b0;
			wdata_ff  <= 8'h00;
			wlane_ff  <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= clock_sync_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_got_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr[11:2];
			end
			if (w_take)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_mapped ? clock_sync_pkg::RESP_OKAY : clock_sync_pkg::RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Source select and sync control
	logic       sync0_ff;
	logic       sync1_ff;
	logic [3:0] src_lo_ff;
	logic [3:0] src_hi_ff;
	logic [4:0] count_ff;

	wire       wr_src_lo = wr_en && hit_src_lo;
	wire       nxt_sync0 = wr_src_lo ? wdata_ff[clock_sync_pkg::SYNC0_POS] : sync0_ff;
	wire       nxt_sync1 = wr_src_lo ? wdata_ff[clock_sync_pkg::SYNC1_POS] : sync1_ff;
	wire [3:0] nxt_src_lo = wr_src_lo ? wdata_ff[3:0] : src_lo_ff;
	wire [3:0] nxt_src_hi = (wr_en && hit_src_hi) ? wdata_ff[3:0] : src_hi_ff;
	wire [7:0] src_all     = {src_hi_ff, src_lo_ff};
	wire [7:0] nxt_src_all = {nxt_src_hi, nxt_src_lo};
	wire  [7:0] nxt_held;

	// Each output follows the sync bit of the loop that feeds it
	generate
		for (genvar i = 0; i < clock_sync_pkg::NUM_OUTPUTS; i++)
		begin : g_out
			assign nxt_held[i] = nxt_src_all[i] ? nxt_sync1 : nxt_sync0;
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync0_ff  <= clock_sync_pkg::SYNC_RESET;
			sync1_ff  <= clock_sync_pkg::SYNC_RESET;
			src_lo_ff <= clock_sync_pkg::SRC_RESET;
			src_hi_ff <= clock_sync_pkg::SRC_RESET;
			count_ff  <= clock_sync_pkg::COUNT_RESET;
		end
		else
		begin
			sync0_ff  <= nxt_sync0;
			sync1_ff  <= nxt_sync1;
			src_lo_ff <= nxt_src_lo;
			src_hi_ff <= nxt_src_hi;
			if (wr_en && hit_count)
				count_ff <= wdata_ff[4:0];
		end
	end

	// ==========================================================
	// Coarse delay on output seven, one clock period per step
	logic       trig_pend_ff;
	logic [4:0] pend_count_ff;
	logic [4:0] stall_cnt_ff;

	wire trig_write = wr_en && hit_trig && wdata_ff[clock_sync_pkg::TRIGGER_POS];
	wire output_seven_kill  = nxt_held[7];
	wire start      = trig_pend_ff && (stall_cnt_ff == 5'h00) && !output_seven_kill;
	wire busy       = trig_pend_ff || (stall_cnt_ff != 5'h00);
	logic [4:0] nxt_stall;

	always_comb
	begin
		nxt_stall = stall_cnt_ff;
		if (output_seven_kill)
			nxt_stall = 5'h00;
		else if (start)
			nxt_stall = pend_count_ff;
		else if (stall_cnt_ff != 5'h00)
			nxt_stall = 5'(stall_cnt_ff - 5'h01);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			trig_pend_ff  <= 1'b0;
			pend_count_ff <= clock_sync_pkg::COUNT_RESET;
			stall_cnt_ff  <= 5'h00;
			divider_ctrl  <= '0;
		end
		else
		begin
			// A new trigger wins over the clear of the pending one
			if (trig_write)
			begin
				trig_pend_ff  <= 1'b1;
				pend_count_ff <= count_ff;
			end
			else if (start || output_seven_kill)
				trig_pend_ff <= 1'b0;
			stall_cnt_ff              <= nxt_stall;
			divider_ctrl.div_reset    <= nxt_held;
			divider_ctrl.phase_clear  <= divider_ctrl.div_reset & ~nxt_held;
			divider_ctrl.output_seven_hold    <= nxt_stall != 5'h00;
		end
	end

	// ==========================================================
	// Bus read path
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire [9:0] ar_idx  = s_axi_araddr[11:2];
	wire       ar_take = s_axi_arvalid && s_axi_arready;
	logic [31:0] rd_word;
	logic        rd_hit;

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (ar_idx)
			clock_sync_pkg::IDX_TRIGGER:   rd_word = {31'h0, busy};
			clock_sync_pkg::IDX_COUNT:     rd_word = {27'h0, count_ff};
			clock_sync_pkg::IDX_STEP:      rd_word = clock_sync_pkg::STEP_WORD;
			clock_sync_pkg::IDX_SOURCE_LO: rd_word = {26'h0, sync1_ff, sync0_ff, src_lo_ff};
			clock_sync_pkg::IDX_SOURCE_HI: rd_word = {28'h0, src_hi_ff};
			default:                       rd_hit  = 1'b0;
		endcase
	end

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= clock_sync_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_hit ? clock_sync_pkg::RESP_OKAY : clock_sync_pkg::RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// ==========================================================
	// Assertions
	a_first_loop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sync0_ff) |-> ((divider_ctrl.div_reset | src_all) == 8'hff))
		else $error("first loop dividers not held");

	a_first_loop_release: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(sync0_ff) && $stable(src_all)) |-> ((divider_ctrl.div_reset & ~src_all) == 8'h00)
		&& ((divider_ctrl.phase_clear | src_all) == 8'hff))
		else $error("first loop dividers not released together");

	a_second_loop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sync1_ff) |-> ((divider_ctrl.div_reset | ~src_all) == 8'hff))
		else $error("second loop dividers not held");

	a_second_loop_release: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(sync1_ff) && $stable(src_all)) |-> ((divider_ctrl.div_reset & src_all) == 8'h00)
		&& ((divider_ctrl.phase_clear | ~src_all) == 8'hff))
		else $error("second loop dividers not released together");

	a_count_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && hit_count) |=> (count_ff == $past(wdata_ff[4:0])))
		else $error("delay count not stored");

	a_trigger_start: assert property (@(posedge aclk) disable iff (!aresetn)
		(start && pend_count_ff != 5'h00) |=> (stall_cnt_ff == $past(pend_count_ff)) && divider_ctrl.output_seven_hold)
		else $error("coarse delay not applied");

	a_vco_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(stall_cnt_ff == 5'h02 && !output_seven_kill && !start) |=> (stall_cnt_ff == 5'h01) ##1 !divider_ctrl.output_seven_hold)
		else $error("coarse step not one period");

	a_fine_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_take && ar_idx == clock_sync_pkg::IDX_STEP) |=> (s_axi_rdata[15:8] == 8'h10))
		else $error("fine step size wrong");

	a_sync_reset: assert property (@(posedge aclk)
		!aresetn |=> (!sync0_ff && !sync1_ff && divider_ctrl.div_reset == 8'h00))
		else $error("sync bits not cleared by reset");

	a_one_adjust: assert property (@(posedge aclk) disable iff (!aresetn)
		trig_write |=> (trig_pend_ff && pend_count_ff == $past(count_ff)))
		else $error("trigger lost or count not sampled");

endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data; logic [31:0] exp; logic [1:0] resp;} row_type;
	// ======
	// Signals
	logic                             aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0]                      s_axi_awaddr, s_axi_araddr;
	logic [31:0]                      s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]                       s_axi_wstrb;
	logic [1:0]                       s_axi_bresp, s_axi_rresp, rsp;
	clock_sync_pkg::divider_ctrl_type divider_ctrl, snap;
	int                               num_errors, checks_done, hold_cycles, hold_rises, h0, r0;
	logic                             hold_prev;
	row_type                          rows [0:8] = '{
		'{1'b0, 12'h2a0, 32'h0, 32'h0, 2'h0}, '{1'b0, 12'h294, 32'h0, 32'h0, 2'h0},
		'{1'b0, 12'h298, 32'h0, 32'h10fa, 2'h0}, '{1'b0, 12'h274, 32'h0, 32'h0, 2'h0},
		'{1'b0, 12'h2a4, 32'h0, 32'h0, 2'h0}, '{1'b0, 12'h100, 32'h0, 32'h0, 2'h2},
		'{1'b1, 12'h294, 32'h3f, 32'h0, 2'h0}, '{1'b0, 12'h294, 32'h0, 32'h1f, 2'h0},
		'{1'b1, 12'h300, 32'h1, 32'h0, 2'h2}};

	output_divider_sync output_divider_sync_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .divider_ctrl(divider_ctrl));

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Counts held cycles and separate holds of output seven
	always @(posedge aclk)
	begin
		hold_prev <= divider_ctrl.output_seven_hold;
		if (divider_ctrl.output_seven_hold === 1'b1) hold_cycles <= hold_cycles + 1;
		if (divider_ctrl.output_seven_hold === 1'b1 && hold_prev !== 1'b1) hold_rises <= hold_rises + 1;
	end

	// ======
	// Tasks
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			#1;
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid & s_axi_bready;
			snap = divider_ctrl;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 40)
		begin
			num_errors++;
			summarize();
		end
	endtask

	task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic ta, tb;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			#1;
			ta = s_axi_arvalid & s_axi_arready;
			tb = s_axi_rvalid & s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tb) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 40)
		begin
			num_errors++;
			summarize();
		end
	endtask

	// ======
	// Stimulus
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].wr) axi_write(rows[i].addr, rows[i].data, rsp);
			else axi_read(rows[i].addr, rd, rsp);
			if (!rows[i].wr) check_word(rd, rows[i].exp, "read data");
			check_word({30'h0, rsp}, {30'h0, rows[i].resp}, "response");
		end
		$display("register rows done");
		// Output seven and output one come from the second loop
		axi_write(12'h2a4, 32'h08, rsp);
		axi_write(12'h2a0, 32'h02, rsp);
		axi_write(12'h2a0, 32'h12, rsp);
		check_word({24'h0, snap.div_reset}, 32'h7d, "first hold");
		axi_write(12'h2a0, 32'h02, rsp);
		check_word({24'h0, snap.div_reset}, 32'h0, "first release");
		check_word({24'h0, snap.phase_clear}, 32'h7d, "first clear");
		#1;
		check_word({24'h0, divider_ctrl.phase_clear}, 32'h0, "clear pulse");
		axi_write(12'h2a0, 32'h22, rsp);
		check_word({24'h0, snap.div_reset}, 32'h82, "second hold");
		axi_write(12'h2a0, 32'h02, rsp);
		check_word({24'h0, snap.div_reset}, 32'h0, "second release");
		check_word({24'h0, snap.phase_clear}, 32'h82, "second clear");
		$display("sync test done");
		axi_write(12'h294, 32'h07, rsp);
		h0 = hold_cycles;
		r0 = hold_rises;
		axi_write(12'h274, 32'h01, rsp);
		axi_read(12'h274, rd, rsp);
		check_word(rd, 32'h1, "busy flag");
		axi_write(12'h294, 32'h02, rsp);
		repeat (20) @(posedge aclk);
		#1;
		check_word(32'(hold_cycles - h0), 32'h7, "hold length");
		check_word(32'(hold_rises - r0), 32'h1, "hold count");
		axi_write(12'h294, 32'h00, rsp);
		h0 = hold_cycles;
		axi_write(12'h274, 32'h01, rsp);
		repeat (10) @(posedge aclk);
		#1;
		check_word(32'(hold_cycles - h0), 32'h0, "zero delay");
		$display("coarse test done");
		axi_write(12'h2a0, 32'h12, rsp);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		check_word({24'h0, divider_ctrl.div_reset}, 32'h0, "reset hold");
		axi_read(12'h2a0, rd, rsp);
		check_word(rd, 32'h0, "reset sync");
		$display("reset test done");
		summarize();
	end
endmodule
